// [sim/tp_flash_model.sv]
// flash array model facing the table pointer unit
// assumes the pclk domain; slow stretches the read latency
`timescale 1ns/1ps
module tp_flash_model
	import tp_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              slow,
	input  wire logic              rd_req,
	input  wire logic [PGM_W-1:0]  addr,
	input  wire logic              cfg,
	output logic      [DATA_W-1:0] rd_data,
	output logic                   rd_valid,
	input  wire logic              wr_start,
	input  wire logic              erase_start,
	output logic                   busy
);
	logic [3:0] wait_q;
	logic [3:0] busy_q;
	////////////////////////////////////////
	// the byte is a fold of the address, so a wrong address shows up
	assign busy = (busy_q != 4'h0);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_q   <= 4'h0;
			busy_q   <= 4'h0;
			rd_valid <= 1'h0;
			rd_data  <= 8'hA5;
		end else begin
			rd_valid <= 1'h0;
			// stale data toggles so a late sample cannot pass
			rd_data  <= ~rd_data;
			if (rd_req && !rd_valid) begin
				wait_q <= wait_q + 4'h1;
				if (wait_q >= (slow ? 4'h5 : 4'h0)) begin
					wait_q   <= 4'h0;
					rd_valid <= 1'h1;
					rd_data  <= addr[7:0] ^ addr[15:8]
						^ {3'h0, addr[20:16]} ^ {cfg, 7'h00};
				end
			end
			if (wr_start || erase_start) begin
				busy_q <= 4'hC;
			end else if (busy_q != 4'h0) begin
				busy_q <= busy_q - 4'h1;
			end
		end
	end
endmodule : tp_flash_model

// [sim/tp_top_tb.sv]
// self-checking bench for the table pointer unit
// assumes tp_top and the flash model share one 25 MHz pclk
`timescale 1ns/1ps
module tp_top_tb;
	import tp_pkg::*;
	logic        pclk = 1'h0;
	logic        presetn = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic        slow = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'hF;
	logic [4:0]  fl_hold_idx = 5'h00;
	logic [31:0] prdata_q, rd_s;
	logic        pready_q, pslverr_q, fl_rd_req_q, fl_cfg_space_q;
	logic        fl_rd_valid, fl_wr_start_q, fl_erase_start_q, fl_busy;
	logic        err_s;
	logic [20:0] fl_addr_q;
	logic [7:0]  fl_rd_data, fl_hold_data_q, d;
	logic [15:0] fl_blk_q, blk_s;
	logic [21:0] p, q;
	logic [1:0]  m;
	int          miscompares = 0;
	int          num_checks = 0;
	int          n_wr = 0;
	int          n_er = 0;

	tp_top #(.AW(8)) tp_top_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata_q(prdata_q),
		.pready_q(pready_q), .pslverr_q(pslverr_q),
		.fl_rd_req_q(fl_rd_req_q), .fl_addr_q(fl_addr_q),
		.fl_cfg_space_q(fl_cfg_space_q), .fl_rd_data(fl_rd_data),
		.fl_rd_valid(fl_rd_valid), .fl_wr_start_q(fl_wr_start_q),
		.fl_erase_start_q(fl_erase_start_q), .fl_blk_q(fl_blk_q),
		.fl_busy(fl_busy), .fl_hold_idx(fl_hold_idx),
		.fl_hold_data_q(fl_hold_data_q));
	tp_flash_model tp_flash_model_i (.clk(pclk), .rst_n(presetn),
		.slow(slow), .rd_req(fl_rd_req_q), .addr(fl_addr_q),
		.cfg(fl_cfg_space_q), .rd_data(fl_rd_data), .rd_valid(fl_rd_valid),
		.wr_start(fl_wr_start_q), .erase_start(fl_erase_start_q),
		.busy(fl_busy));
	////////////////////////////////////////
	initial begin
		forever #20 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (fl_wr_start_q === 1'h1) n_wr++;
		if (fl_erase_start_q === 1'h1) n_er++;
		if (fl_wr_start_q === 1'h1 || fl_erase_start_q === 1'h1) blk_s = fl_blk_q;
	end

	function automatic logic [21:0] step(logic [21:0] a, logic [1:0] k);
		if (k == OP_KEEP) return a;
		if (k == OP_POST_DEC) return {a[21], a[20:0] - 21'h000001};
		return {a[21], a[20:0] + 21'h000001};
	endfunction : step

	function automatic logic [7:0] fbyte(logic [21:0] a);
		return a[7:0] ^ a[15:8] ^ {3'h0, a[20:16]} ^ {a[21], 7'h00};
	endfunction : fbyte

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	// request held until pready is sampled high, then released
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel   <= 1'h1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready_q !== 1'h1 && n < 20);
		rd_s = prdata_q;
		err_s = pslverr_q;
		psel    <= 1'h0;
		penable <= 1'h0;
		if (n >= 20) begin
			miscompares++;
			print_verdict();
		end
	endtask : apb

	task automatic set_ptr(input logic [21:0] a);
		apb(1'h1, OFS_PTR_LOW, {24'h0, a[7:0]});
		apb(1'h1, OFS_PTR_HIGH, {24'h0, a[15:8]});
		apb(1'h1, OFS_PTR_UPPER, {26'h0, a[21:16]});
	endtask : set_ptr

	task automatic get_ptr(output logic [21:0] a);
		apb(1'h0, OFS_PTR_LOW, 32'h0);
		a[7:0] = rd_s[7:0];
		apb(1'h0, OFS_PTR_HIGH, 32'h0);
		a[15:8] = rd_s[7:0];
		apb(1'h0, OFS_PTR_UPPER, 32'h0);
		a[21:16] = rd_s[5:0];
	endtask : get_ptr

	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			apb(1'h0, OFS_STATUS, 32'h0);
			n++;
		end while (rd_s[1:0] !== 2'h0 && n < 40);
		if (n >= 40) begin
			miscompares++;
			print_verdict();
		end
	endtask : wait_idle
	////////////////////////////////////////
	initial begin
		void'($urandom(32'h193C5801));
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		get_ptr(q);
		chk("ptr_reset", 32'h0, {10'h0, q});
		apb(1'h0, OFS_LATCH, 32'h0);
		chk("latch_reset", 32'h0, rd_s);
		apb(1'h0, 8'h1C, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, err_s});
		pstrb <= 4'hE;
		apb(1'h1, OFS_LATCH, 32'h5A);
		pstrb <= 4'hF;
		apb(1'h0, OFS_LATCH, 32'h0);
		chk("latch_strb", 32'h0, rd_s);
		apb(1'h1, OFS_PTR_UPPER, 32'hFF);
		apb(1'h0, OFS_PTR_UPPER, 32'h0);
		chk("upper_rd", 32'h3F, rd_s);
		$display("test registers done");
		// wrap corners first, then random pointers incl. config space
		for (int i = 0; i < 12; i++) begin
			p = (i < 4) ? 22'h3FFFFF : (i < 8) ? 22'h0 : 22'($urandom);
			m = 2'(i);
			slow <= 1'($urandom);
			set_ptr(p);
			apb(1'h1, OFS_CMD, {30'h0, m});
			wait_idle();
			q = (m == OP_PRE_INC) ? step(p, m) : p;
			apb(1'h0, OFS_LATCH, 32'h0);
			chk("rd_latch", {24'h0, fbyte(q)}, rd_s);
			get_ptr(q);
			chk("rd_ptr", {10'h0, step(p, m)}, {10'h0, q});
		end
		$display("test table reads done");
		for (int i = 0; i < 8; i++) begin
			p = 22'($urandom);
			m = 2'(i);
			d = 8'($urandom);
			apb(1'h1, OFS_LATCH, {24'h0, d});
			set_ptr(p);
			q = (m == OP_PRE_INC) ? step(p, m) : p;
			fl_hold_idx <= q[4:0];
			apb(1'h1, OFS_CMD, {29'h0, 1'h1, m});
			repeat (2) @(posedge pclk);
			chk("hold", {24'h0, d}, {24'h0, fl_hold_data_q});
			get_ptr(q);
			chk("wr_ptr", {10'h0, step(p, m)}, {10'h0, q});
		end
		$display("test table writes done");
		for (int i = 0; i < 2; i++) begin
			p = 22'($urandom);
			set_ptr(p);
			apb(1'h1, OFS_FLASH_CTL, (i == 0) ? 32'h1 : 32'h2);
			repeat (2) @(posedge pclk);
			chk("blk", {16'h0, p[21:6]}, {16'h0, blk_s});
			apb(1'h1, OFS_CMD, 32'h1);
			apb(1'h0, OFS_STATUS, 32'h0);
			chk("busy_err", 32'h6, rd_s);
			wait_idle();
			get_ptr(q);
			chk("busy_ptr", {10'h0, p}, {10'h0, q});
			apb(1'h1, OFS_STATUS, 32'h4);
			apb(1'h0, OFS_STATUS, 32'h0);
			chk("err_clr", 32'h0, rd_s);
		end
		chk("n_wr", 32'h1, 32'(n_wr));
		chk("n_er", 32'h1, 32'(n_er));
		$display("test flash starts done");
		print_verdict();
	end
endmodule : tp_top_tb

// [src/tp_hold_mem.sv]
// holding registers for a program memory block write
// one write port from the table unit, one registered read port
`timescale 1ns/1ps
module tp_hold_mem #(
	parameter int DW = 8,
	parameter int AW = 5,
	parameter int DEPTH = 32
) (
	input  wire logic          clk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata_q
);
	logic [DW-1:0] mem_q [DEPTH];

	// no reset: contents are don't-care until software fills them
	always_ff @(posedge clk) begin
		if (we) begin
			mem_q[waddr] <= wdata;
		end
		rdata_q <= mem_q[raddr];
	end
endmodule : tp_hold_mem

// [src/tp_pkg.sv]
// table pointer unit: shared constants
// assumes a 32-bit apb bus with byte addresses
package tp_pkg;
	localparam int PTR_W = 22;
	localparam int PGM_W = 21;
	localparam int BLK_LSB = 6;
	localparam int HOLD_AW = 5;
	localparam int HOLD_DEPTH = 32;
	localparam int DATA_W = 8;
	localparam int APB_AW = 8;
	localparam int CFG_BIT = 21;
	localparam int PTR_HIGH_LSB = 8;
	localparam int PTR_UPPER_LSB = 16;

	// register byte offsets
	localparam logic [7:0] OFS_LATCH = 8'h00;
	localparam logic [7:0] OFS_PTR_LOW = 8'h04;
	localparam logic [7:0] OFS_PTR_HIGH = 8'h08;
	localparam logic [7:0] OFS_PTR_UPPER = 8'h0C;
	localparam logic [7:0] OFS_CMD = 8'h10;
	localparam logic [7:0] OFS_FLASH_CTL = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;

	// command register fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_DIR_BIT = 2;
	// pointer update modes
	localparam logic [1:0] OP_KEEP = 2'h0;
	localparam logic [1:0] OP_POST_INC = 2'h1;
	localparam logic [1:0] OP_POST_DEC = 2'h2;
	localparam logic [1:0] OP_PRE_INC = 2'h3;

	// flash control and status bits
	localparam int FC_WRITE_BIT = 0;
	localparam int FC_ERASE_BIT = 1;
	localparam int ST_RD_BUSY = 0;
	localparam int ST_FL_BUSY = 1;
	localparam int ST_CMD_ERR = 2;

	localparam logic [PTR_W-1:0] PTR_RESET = 22'h000000;
	localparam logic [DATA_W-1:0] LATCH_RESET = 8'h00;
	localparam logic [PGM_W-1:0] PGM_ONE = 21'h000001;
	localparam logic [31:0] RD_ZERO = 32'h00000000;

	typedef enum logic [0:0] {
		TP_IDLE,
		TP_RD_WAIT
	} tp_state_t;
endpackage : tp_pkg

// [src/tp_top.sv]
// table pointer unit: byte moves between program flash and data ram
// assumes the flash array runs on pclk and answers reads with a pulse
//
// Functional notes
// - eight-bit latch holds each transferred byte
// - pointer is upper, high, low bytes concatenated
// - low 21 pointer bits address program memory
// - top pointer bit selects id/config space
// - four pointer updates: keep, post-inc, post-dec, pre-inc
// - steps never change the top pointer bit
// - table read fetches addressed byte into latch
// - table write stores latch in holding register
// - block write uses pointer bits 21 to 6
// - erase uses bits 21 to 6, ignores 5:0
`timescale 1ns/1ps
module tp_top
	import tp_pkg::*;
#(
	parameter int AW = APB_AW
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [AW-1:0]     paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata_q,
	output logic                   pready_q,
	output logic                   pslverr_q,
	output logic                   fl_rd_req_q,
	output logic      [PGM_W-1:0]  fl_addr_q,
	output logic                   fl_cfg_space_q,
	input  wire logic [DATA_W-1:0] fl_rd_data,
	input  wire logic              fl_rd_valid,
	output logic                   fl_wr_start_q,
	output logic                   fl_erase_start_q,
	output logic      [15:0]       fl_blk_q,
	input  wire logic              fl_busy,
	input  wire logic [HOLD_AW-1:0] fl_hold_idx,
	output logic      [DATA_W-1:0] fl_hold_data_q
);

////////////////////////////////////////////////////////////////////////
// pointer arithmetic

	function automatic logic [PTR_W-1:0] ptr_step(
		input logic [PTR_W-1:0] p,
		input logic             dec
	);
		logic [PGM_W-1:0] low;
		low = dec ? (p[PGM_W-1:0] - PGM_ONE) : (p[PGM_W-1:0] + PGM_ONE);
		ptr_step = {p[CFG_BIT], low};
	endfunction : ptr_step

////////////////////////////////////////////////////////////////////////
// state

	logic [DATA_W-1:0] latch_q;
	logic [PTR_W-1:0]  ptr_q;
	tp_state_t         state_q;
	logic              err_q;

////////////////////////////////////////////////////////////////////////
// apb decode

	wire setup = psel & ~penable;
	wire wr_en = psel & penable & pwrite & pready_q;
	wire [APB_AW-1:0] ofs = paddr[APB_AW-1:0];
	wire hit_latch = (ofs == OFS_LATCH);
	wire hit_low = (ofs == OFS_PTR_LOW);
	wire hit_high = (ofs == OFS_PTR_HIGH);
	wire hit_upper = (ofs == OFS_PTR_UPPER);
	wire hit_cmd = (ofs == OFS_CMD);
	wire hit_fctl = (ofs == OFS_FLASH_CTL);
	wire hit_stat = (ofs == OFS_STATUS);
	wire hit_any = hit_latch | hit_low | hit_high | hit_upper | hit_cmd
		| hit_fctl | hit_stat;
	wire upper_addr_ok = (paddr >> APB_AW) == '0;
	wire mapped = hit_any & upper_addr_ok;
	wire lane0 = pstrb[0];
	wire wr_ok = wr_en & mapped & lane0;

	wire [DATA_W-1:0] upper_rd_w = DATA_W'(ptr_q[PTR_W-1:PTR_UPPER_LSB]);
	wire [31:0] status_w = {29'h0, err_q, fl_busy,
		state_q == TP_RD_WAIT};

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = RD_ZERO;
		if (hit_latch) begin
			rd_mux = {24'h0, latch_q};
		end else if (hit_low) begin
			rd_mux = {24'h0, ptr_q[PTR_HIGH_LSB-1:0]};
		end else if (hit_high) begin
			rd_mux = {24'h0, ptr_q[PTR_UPPER_LSB-1:PTR_HIGH_LSB]};
		end else if (hit_upper) begin
			rd_mux = {24'h0, upper_rd_w};
		end else if (hit_stat) begin
			rd_mux = status_w;
		end
	end

////////////////////////////////////////////////////////////////////////
// table instruction decode

	wire busy = (state_q != TP_IDLE) | fl_busy;
	wire cmd_wr = wr_ok & hit_cmd;
	wire cmd_go = cmd_wr & ~busy;
	wire [1:0] op = pwdata[CMD_OP_LSB +: 2];
	wire is_wt = pwdata[CMD_DIR_BIT];
	wire rd_go = cmd_go & ~is_wt;
	wire wt_go = cmd_go & is_wt;

	// pre-increment moves the pointer before the access address is formed
	wire [PTR_W-1:0] ptr_inc = ptr_step(ptr_q, 1'b0);
	wire [PTR_W-1:0] ptr_dec = ptr_step(ptr_q, 1'b1);
	wire [PTR_W-1:0] acc_addr = (op == OP_PRE_INC) ? ptr_inc : ptr_q;
	wire [PTR_W-1:0] ptr_after =
		(op == OP_KEEP)     ? ptr_q :
		(op == OP_POST_DEC) ? ptr_dec : ptr_inc;

	wire fc_wr = wr_ok & hit_fctl & ~busy;
	wire fc_write = fc_wr & pwdata[FC_WRITE_BIT];
	wire fc_erase = fc_wr & pwdata[FC_ERASE_BIT] & ~pwdata[FC_WRITE_BIT];
	wire refused = (cmd_wr | (wr_ok & hit_fctl)) & busy;
	wire err_clr = wr_ok & hit_stat & pwdata[ST_CMD_ERR];

	wire hold_we = wt_go;
	wire [HOLD_AW-1:0] hold_waddr = acc_addr[HOLD_AW-1:0];

////////////////////////////////////////////////////////////////////////
// apb answer: registered in setup so access completes without wait

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= RD_ZERO;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup & ~mapped;
			prdata_q <= (setup & ~pwrite & mapped) ? rd_mux : RD_ZERO;
		end
	end

////////////////////////////////////////////////////////////////////////
// pointer and latch

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_q <= PTR_RESET;
		end else if (cmd_go) begin
			ptr_q <= ptr_after;
		end else if (wr_ok & hit_low) begin
			ptr_q[PTR_HIGH_LSB-1:0] <= pwdata[DATA_W-1:0];
		end else if (wr_ok & hit_high) begin
			ptr_q[PTR_UPPER_LSB-1:PTR_HIGH_LSB] <=
				pwdata[DATA_W-1:0];
		end else if (wr_ok & hit_upper) begin
			ptr_q[PTR_W-1:PTR_UPPER_LSB] <=
				pwdata[PTR_W-PTR_UPPER_LSB-1:0];
		end
	end

	// returning flash data beats a software write to the latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch_q <= LATCH_RESET;
		end else if (state_q == TP_RD_WAIT && fl_rd_valid) begin
			latch_q <= fl_rd_data;
		end else if (wr_ok & hit_latch) begin
			latch_q <= pwdata[DATA_W-1:0];
		end
	end

////////////////////////////////////////////////////////////////////////
// table read sequencer

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= TP_IDLE;
			fl_rd_req_q <= 1'b0;
			fl_addr_q <= '0;
			fl_cfg_space_q <= 1'b0;
		end else begin
			case (state_q)
				TP_IDLE: begin
					if (rd_go) begin
						state_q <= TP_RD_WAIT;
						fl_rd_req_q <= 1'b1;
						fl_addr_q <= acc_addr[PGM_W-1:0];
						fl_cfg_space_q <= acc_addr[CFG_BIT];
					end
				end
				TP_RD_WAIT: begin
					if (fl_rd_valid) begin
						state_q <= TP_IDLE;
						fl_rd_req_q <= 1'b0;
					end
				end
				default: state_q <= TP_IDLE;
			endcase
		end
	end

////////////////////////////////////////////////////////////////////////
// block write / erase launch and error flag

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fl_wr_start_q <= 1'b0;
			fl_erase_start_q <= 1'b0;
			fl_blk_q <= '0;
		end else begin
			fl_wr_start_q <= fc_write;
			fl_erase_start_q <= fc_erase;
			if (fc_write | fc_erase) begin
				fl_blk_q <= ptr_q[PTR_W-1:BLK_LSB];
			end
		end
	end

	// a new refusal wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_q <= 1'b0;
		end else if (refused) begin
			err_q <= 1'b1;
		end else if (err_clr) begin
			err_q <= 1'b0;
		end
	end

////////////////////////////////////////////////////////////////////////
// holding registers

	tp_hold_mem #(
		.DW    (DATA_W),
		.AW    (HOLD_AW),
		.DEPTH (HOLD_DEPTH)
	) u_hold (
		.clk     (pclk),
		.we      (hold_we),
		.waddr   (hold_waddr),
		.wdata   (latch_q),
		.raddr   (fl_hold_idx),
		.rdata_q (fl_hold_data_q)
	);

////////////////////////////////////////////////////////////////////////
// checks

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_latch_load: assert property (
		state_q == TP_RD_WAIT && fl_rd_valid |=>
			latch_q == $past(fl_rd_data) && state_q == TP_IDLE)
		else $error("latch did not take flash byte");

	a_rd_addr: assert property (
		rd_go && op != OP_PRE_INC |=> fl_rd_req_q &&
			fl_addr_q == $past(ptr_q[PGM_W-1:0]))
		else $error("read address not taken from pointer");

	a_cfg_select: assert property (
		rd_go |=> fl_cfg_space_q == $past(ptr_q[CFG_BIT]))
		else $error("config space select wrong");

	a_msb_kept: assert property (
		cmd_go |=> ptr_q[CFG_BIT] == $past(ptr_q[CFG_BIT]))
		else $error("pointer top bit changed by step");

	a_post_inc: assert property (
		cmd_go && op == OP_POST_INC |=>
			ptr_q[PGM_W-1:0] == $past(ptr_q[PGM_W-1:0]) + PGM_ONE)
		else $error("post increment wrong");

	a_post_dec: assert property (
		cmd_go && op == OP_POST_DEC |=>
			ptr_q[PGM_W-1:0] == $past(ptr_q[PGM_W-1:0]) - PGM_ONE)
		else $error("post decrement wrong");

	a_pre_inc: assert property (
		rd_go && op == OP_PRE_INC |=>
			fl_addr_q == $past(ptr_q[PGM_W-1:0]) + PGM_ONE &&
			fl_addr_q == ptr_q[PGM_W-1:0])
		else $error("pre increment access wrong");

	a_hold_data: assert property (
		wt_go && fl_hold_idx == hold_waddr ##1 fl_hold_idx == $past(hold_waddr)
			|=> fl_hold_data_q == $past(latch_q, 2))
		else $error("holding register not written from latch");

	a_blk_write: assert property (
		fc_write |=> fl_wr_start_q && fl_blk_q == $past(ptr_q[21:6]))
		else $error("write block address wrong");

	a_blk_erase: assert property (
		fc_erase |=> fl_erase_start_q && !fl_wr_start_q &&
			fl_blk_q == $past(ptr_q[21:6]))
		else $error("erase block address wrong");

	a_latch_width: assert property (
		wr_ok && hit_latch && state_q == TP_IDLE |=>
			latch_q == $past(pwdata[7:0]))
		else $error("latch write lost");

	a_ptr_concat: assert property (
		wr_ok && hit_upper && !cmd_go |=>
			ptr_q[PTR_W-1:16] == $past(pwdata[5:0]) &&
			ptr_q[15:0] == $past(ptr_q[15:0]))
		else $error("upper pointer byte misplaced");

	a_keep_ptr: assert property (
		cmd_go && op == OP_KEEP |=> ptr_q == $past(ptr_q))
		else $error("pointer moved on keep");

	// a refused command must leave the pointer alone and flag it
	a_busy_refuse: assert property (
		cmd_wr && busy |=> ptr_q == $past(ptr_q) && err_q)
		else $error("refused command changed pointer");

	a_rd_req_hold: assert property (
		fl_rd_req_q && !fl_rd_valid |=>
			fl_rd_req_q && $stable(fl_addr_q))
		else $error("read request dropped early");

	a_wt_no_read: assert property (
		wt_go |=> !fl_rd_req_q && state_q == TP_IDLE)
		else $error("table write started a read");

	a_wr_pulse: assert property (
		fl_wr_start_q |=> !fl_wr_start_q)
		else $error("write start longer than one cycle");

	a_erase_pulse: assert property (
		fl_erase_start_q |=> !fl_erase_start_q)
		else $error("erase start longer than one cycle");

endmodule : tp_top
